//--- hdl/dmr_pkg.sv
// Constants and types shared by the PLL mode and reference-select control block
package dmr_pkg;
   // ==========================================================================
   // Register offsets
   localparam logic [7:0] ADDR_A_MODE_REFSEL = 8'h33;
   localparam logic [7:0] ADDR_A_FAIL_MASKS = 8'h34;
   localparam logic [7:0] ADDR_B_LOOP_CTRL = 8'h35;
   localparam logic [7:0] ADDR_B_PRIO_23 = 8'h36;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] RST_A_MODE_REFSEL = 8'h0F;
   localparam logic [7:0] RST_A_FAIL_MASKS = 8'h87;
   localparam logic [7:0] RST_B_LOOP_CTRL = 8'h0C;
   localparam logic [7:0] RST_B_PRIO_23 = 8'h32;

   // ==========================================================================
   // Writable bit masks; cleared bits are reserved and keep their reset value
   localparam logic [7:0] WMASK_A_MODE_REFSEL = 8'hE3;
   localparam logic [7:0] WMASK_A_FAIL_MASKS = 8'hFF;
   localparam logic [7:0] WMASK_B_LOOP_CTRL = 8'hFC;
   localparam logic [7:0] WMASK_B_PRIO_23 = 8'h77;

   // ==========================================================================
   // Field positions
   localparam int MODE_LSB = 0;
   localparam int EXT_FB_BIT = 5;
   localparam int REFSEL_LSB = 6;
   localparam int HOLD_MASK_LSB = 0;
   localparam int SWITCH_MASK_LSB = 4;
   localparam int SLOPE_LSB = 2;
   localparam int ALIGN_BIT = 4;
   localparam int BW_LSB = 5;

   // ==========================================================================
   // Codes
   localparam logic [1:0] MODE_FREERUN = 2'h0;
   localparam logic [1:0] MODE_FORCED_HOLD = 2'h1;
   localparam logic [1:0] MODE_FORCED_LOCK = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;
   localparam logic [2:0] BW_RESERVED = 3'h7;
   localparam logic [2:0] PRIO_DISABLED = 3'h7;
   localparam int NUM_REFS = 4;
   localparam int NUM_FAIL_TYPES = 4;

   // ==========================================================================
   // Slope limits in ns per second (0 means unlimited) and base bandwidth
   localparam logic [19:0] SLOPE_61_US_NS = 20'h0EE48;
   localparam logic [19:0] SLOPE_7P5_US_NS = 20'h01D4C;
   localparam logic [19:0] SLOPE_0P885_US_NS = 20'h00375;
   localparam logic [19:0] SLOPE_UNLIMITED = 20'h00000;
   localparam logic [9:0] BW_BASE_HZ = 10'h00E;

   // ==========================================================================
   // Loop state of the first PLL
   typedef enum logic [2:0] {
      ST_FREERUN = 3'h1,
      ST_LOCKED = 3'h2,
      ST_HOLDOVER = 3'h4
   } dmr_state_e;
endpackage

//--- hdl/dmr_sel_if.sv
// Interface between register control and the reference selector
`timescale 1ns/1ps
interface dmr_sel_if;
   logic [1:0] mode;
   logic [1:0] forced_ref;
   logic [3:0] hold_mask;
   logic [3:0] switch_mask;
   logic [11:0] prio_codes;
   logic [15:0] fail;
   dmr_pkg::dmr_state_e state;
   logic [1:0] sel_ref;

   // Register side drives settings and reads the loop state
   modport ctl (
      output mode, forced_ref, hold_mask, switch_mask, prio_codes, fail,
      input state, sel_ref
   );
   // Selector side
   modport sel (
      input mode, forced_ref, hold_mask, switch_mask, prio_codes, fail,
      output state, sel_ref
   );
endinterface

//--- hdl/dmr_ref_selector.sv
// Reference selection and loop state machine for the first PLL
`timescale 1ns/1ps
module dmr_ref_selector (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Settings and state
   dmr_sel_if.sel sel
);
   dmr_pkg::dmr_state_e state_ff, nxt_state;
   logic [1:0] sel_ff, nxt_sel;
   logic [3:0] hold_bad, switch_bad, cand_ok;
   logic [2:0] best_prio;
   logic [1:0] best;
   logic found;

   // ==========================================================================
   // Failure qualification
   // [RQ21] mask each failure for holdover and switching; candidates use raw failures
   always_comb begin
      for (int r = 0; r < dmr_pkg::NUM_REFS; r++) begin
         // [RQ11] holdover mask gating
         hold_bad[r] = |(sel.fail[4*r +: 4] & sel.hold_mask);
         // [RQ13] switch mask gating
         switch_bad[r] = |(sel.fail[4*r +: 4] & sel.switch_mask);
         // [RQ20] disabled priority excluded
         cand_ok[r] = (sel.fail[4*r +: 4] == 4'h0) &&
                      (sel.prio_codes[3*r +: 3] != dmr_pkg::PRIO_DISABLED);
      end
   end

   // Best candidate: lowest priority number, lowest index on a tie
   always_comb begin
      best_prio = dmr_pkg::PRIO_DISABLED;
      best = 2'h0;
      found = 1'b0;
      for (int r = 0; r < dmr_pkg::NUM_REFS; r++) begin
         if (cand_ok[r] && (!found || sel.prio_codes[3*r +: 3] < best_prio)) begin
            best_prio = sel.prio_codes[3*r +: 3];
            best = 2'(r);
            found = 1'b1;
         end
      end
   end

   // ==========================================================================
   // Loop state machine
   always_comb begin
      nxt_state = state_ff;
      nxt_sel = sel_ff;
      case (sel.mode)
         // [RQ5] oscillator only
         dmr_pkg::MODE_FREERUN: begin
            nxt_state = dmr_pkg::ST_FREERUN;
         end
         // [RQ4] hold on last reference
         dmr_pkg::MODE_FORCED_HOLD: begin
            nxt_state = dmr_pkg::ST_HOLDOVER;
         end
         // [RQ3] forced lock, no switching
         dmr_pkg::MODE_FORCED_LOCK: begin
            nxt_sel = sel.forced_ref;
            nxt_state = hold_bad[sel.forced_ref] ? dmr_pkg::ST_HOLDOVER
                                                 : dmr_pkg::ST_LOCKED;
         end
         default: begin
            // [RQ2] automatic selection
            if (state_ff == dmr_pkg::ST_LOCKED && !switch_bad[sel_ff] &&
                sel.prio_codes[3*sel_ff +: 3] != dmr_pkg::PRIO_DISABLED) begin
               // [RQ18] revert to better reference
               // [RQ19] equal priority stays put
               if (found && best_prio < sel.prio_codes[3*sel_ff +: 3]) begin
                  nxt_sel = best;
               end
            end else if (found) begin
               nxt_sel = best;
               nxt_state = dmr_pkg::ST_LOCKED;
            end else if (hold_bad[sel_ff] || state_ff != dmr_pkg::ST_LOCKED ||
                         sel.prio_codes[3*sel_ff +: 3] == dmr_pkg::PRIO_DISABLED) begin
               nxt_state = dmr_pkg::ST_HOLDOVER;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= dmr_pkg::ST_FREERUN;
         sel_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         sel_ff <= nxt_sel;
      end
   end

   assign sel.state = state_ff;
   assign sel.sel_ref = sel_ff;

   // ==========================================================================
   // Checks
   sequence forced_ok_s;
      sel.mode == dmr_pkg::MODE_FORCED_LOCK && !hold_bad[sel.forced_ref];
   endsequence

   forced_lock_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ3]
      forced_ok_s |=> state_ff == dmr_pkg::ST_LOCKED && sel_ff == $past(sel.forced_ref))
      else $error("forced lock not taken");
   forced_fail_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ3]
      sel.mode == dmr_pkg::MODE_FORCED_LOCK && hold_bad[sel.forced_ref]
      |=> state_ff == dmr_pkg::ST_HOLDOVER)
      else $error("forced reference failure did not hold over");
   hold_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ4]
      sel.mode == dmr_pkg::MODE_FORCED_HOLD
      |=> state_ff == dmr_pkg::ST_HOLDOVER && sel_ff == $past(sel_ff))
      else $error("forced holdover moved");
   freerun_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ5]
      sel.mode == dmr_pkg::MODE_FREERUN |=> state_ff == dmr_pkg::ST_FREERUN)
      else $error("freerun not entered");
   auto_lock_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ2]
      sel.mode == dmr_pkg::MODE_AUTO && found |=> state_ff == dmr_pkg::ST_LOCKED)
      else $error("holdover with a reference available");
endmodule // dmr_ref_selector

//--- hdl/dmr_control.sv
// Mode, reference-select and loop settings for two PLL channels
//
// Functional notes
// [RQ1] Mode code picks freerun, holdover, lock, automatic
// [RQ2] Automatic picks by priority; holdover when none
// [RQ3] Forced lock holds over, never switches
// [RQ4] Forced holdover ignores references, keeps last
// [RQ5] Freerun runs from crystal oscillator only
// [RQ6] Feedback enable bit turns on delay compensation
// [RQ7] One shared feedback phase for enabled PLLs
// [RQ8] Automatic mode: reference field reports selection
// [RQ9] Forced lock mode: reference field chooses reference
// [RQ10] Freerun and holdover ignore reference field
// [RQ11] Holdover mask zero blocks holdover per failure
// [RQ12] Software never sets guard bit alone
// [RQ13] Switch mask zero blocks switching per failure
// [RQ14] Slope field picks 61, 7.5, 0.885, unlimited
// [RQ15] Align-clear bit aligns second PLL phase
// [RQ16] Software keeps align-clear low for hitless switching
// [RQ17] Bandwidth code picks 14 to 896 Hz
// [RQ18] Automatic mode reverts to better priority
// [RQ19] Equal priority recovery causes no switch back
// [RQ20] Priority code 111 excludes the reference
// [RQ21] Monitor failures are masked before use; candidate selection uses them unmasked
// [RQ22] Reserved bits keep reset values
`timescale 1ns/1ps
module dmr_control (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic wr_en_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_en_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   // Monitor inputs: index ref*4 + type (loss, cycle, frequency, guard)
   input wire logic [15:0] ref_fail_i,
   input wire logic [11:0] pll_a_priority_i,
   // First PLL status and controls
   output logic [2:0] pll_a_state_o,
   output logic [1:0] pll_a_selected_ref_o,
   output logic pll_a_external_feedback_enable_o,
   // Second PLL controls
   output logic [19:0] pll_b_slope_limit_o,
   output logic pll_b_phase_align_clear_o,
   output logic [9:0] pll_b_bandwidth_hz_o
);
   // ==========================================================================
   // Decode helpers
   function automatic logic [19:0] slope_ns(input logic [1:0] code);
      // [RQ14] slope limit table
      case (code)
         2'h0: slope_ns = dmr_pkg::SLOPE_61_US_NS;
         2'h1: slope_ns = dmr_pkg::SLOPE_7P5_US_NS;
         2'h2: slope_ns = dmr_pkg::SLOPE_0P885_US_NS;
         default: slope_ns = dmr_pkg::SLOPE_UNLIMITED;
      endcase
   endfunction

   // Bandwidth doubles with each code step
   function automatic logic [9:0] bw_hz(input logic [2:0] code);
      bw_hz = dmr_pkg::BW_BASE_HZ << code;
   endfunction

   // Merge written bits into writable positions only
   function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] wmask);
      merge = (old_v & ~wmask) | (new_v & wmask);
   endfunction

   // ==========================================================================
   // Registers
   logic [7:0] mode_refsel_ff, nxt_mode_refsel;
   logic [7:0] fail_masks_ff, nxt_fail_masks;
   logic [7:0] b_loop_ff, nxt_b_loop;
   logic [7:0] b_prio_ff, nxt_b_prio;
   logic [7:0] rd_data_ff, nxt_rd_data;
   logic rd_valid_ff, nxt_rd_valid;
   logic ext_fb_ff, nxt_ext_fb;
   logic [19:0] slope_ff, nxt_slope;
   logic align_ff, nxt_align;
   logic [9:0] bw_ff, nxt_bw;
   logic [7:0] cand;
   logic [7:0] mode_read;

   // Settings travel as one bundle
   dmr_sel_if sel_bus ();

   // Register writes
   always_comb begin
      nxt_mode_refsel = mode_refsel_ff;
      nxt_fail_masks = fail_masks_ff;
      nxt_b_loop = b_loop_ff;
      nxt_b_prio = b_prio_ff;
      cand = 8'h00;
      if (wr_en_i) begin
         if (addr_i == dmr_pkg::ADDR_A_MODE_REFSEL) begin
            // [RQ22] reserved bits protected
            cand = merge(mode_refsel_ff, wr_data_i, dmr_pkg::WMASK_A_MODE_REFSEL);
            // [RQ8] status field not writable in automatic
            if (wr_data_i[dmr_pkg::MODE_LSB +: 2] == dmr_pkg::MODE_AUTO) begin
               cand[dmr_pkg::REFSEL_LSB +: 2] = mode_refsel_ff[dmr_pkg::REFSEL_LSB +: 2];
            end
            nxt_mode_refsel = cand;
         end else if (addr_i == dmr_pkg::ADDR_A_FAIL_MASKS) begin
            nxt_fail_masks = merge(fail_masks_ff, wr_data_i, dmr_pkg::WMASK_A_FAIL_MASKS);
         end else if (addr_i == dmr_pkg::ADDR_B_LOOP_CTRL) begin
            cand = merge(b_loop_ff, wr_data_i, dmr_pkg::WMASK_B_LOOP_CTRL);
            // [RQ17] reserved bandwidth code refused
            if (cand[dmr_pkg::BW_LSB +: 3] == dmr_pkg::BW_RESERVED) begin
               cand[dmr_pkg::BW_LSB +: 3] = b_loop_ff[dmr_pkg::BW_LSB +: 3];
            end
            // Loop keeps a legal bandwidth
            nxt_b_loop = cand;
         end else if (addr_i == dmr_pkg::ADDR_B_PRIO_23) begin
            // Storage only here
            nxt_b_prio = merge(b_prio_ff, wr_data_i, dmr_pkg::WMASK_B_PRIO_23);
         end
      end
   end

   // Register file, reset to defaults
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_refsel_ff <= dmr_pkg::RST_A_MODE_REFSEL;
         fail_masks_ff <= dmr_pkg::RST_A_FAIL_MASKS;
         b_loop_ff <= dmr_pkg::RST_B_LOOP_CTRL;
         b_prio_ff <= dmr_pkg::RST_B_PRIO_23;
      end else begin
         mode_refsel_ff <= nxt_mode_refsel;
         fail_masks_ff <= nxt_fail_masks;
         b_loop_ff <= nxt_b_loop;
         b_prio_ff <= nxt_b_prio;
      end
   end

   // ==========================================================================
   // Register reads, one cycle after the request; unmapped reads return zero
   always_comb begin
      mode_read = mode_refsel_ff;
      // [RQ8] live selection shown in automatic
      if (mode_refsel_ff[dmr_pkg::MODE_LSB +: 2] == dmr_pkg::MODE_AUTO) begin
         mode_read[dmr_pkg::REFSEL_LSB +: 2] = sel_bus.sel_ref;
      end
      // Unmapped reads still answer
      nxt_rd_valid = rd_en_i;
      nxt_rd_data = 8'h00;
      if (rd_en_i) begin
         if (addr_i == dmr_pkg::ADDR_A_MODE_REFSEL) begin
            nxt_rd_data = mode_read;
         end else if (addr_i == dmr_pkg::ADDR_A_FAIL_MASKS) begin
            nxt_rd_data = fail_masks_ff;
         end else if (addr_i == dmr_pkg::ADDR_B_LOOP_CTRL) begin
            nxt_rd_data = b_loop_ff;
         end else if (addr_i == dmr_pkg::ADDR_B_PRIO_23) begin
            nxt_rd_data = b_prio_ff;
         end
      end
   end

   // Read answer one edge later
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   // ==========================================================================
   // Selector hookup
   // [RQ1] mode code drives the selector
   assign sel_bus.mode = mode_refsel_ff[dmr_pkg::MODE_LSB +: 2];
   // [RQ9] forced reference from control field
   // [RQ10] selector only uses it when forced
   assign sel_bus.forced_ref = mode_refsel_ff[dmr_pkg::REFSEL_LSB +: 2];
   assign sel_bus.hold_mask = fail_masks_ff[dmr_pkg::HOLD_MASK_LSB +: 4];
   assign sel_bus.switch_mask = fail_masks_ff[dmr_pkg::SWITCH_MASK_LSB +: 4];
   // Priority register lies elsewhere
   assign sel_bus.prio_codes = pll_a_priority_i;
   // Selector applies the masks
   assign sel_bus.fail = ref_fail_i;

   dmr_ref_selector u_sel (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .sel(sel_bus.sel)
   );

   // ==========================================================================
   // Loop settings, registered so each output comes from a flip-flop
   always_comb begin
      // [RQ6] feedback compensation enable
      // [RQ7] single shared feedback phase
      nxt_ext_fb = mode_refsel_ff[dmr_pkg::EXT_FB_BIT];
      // One edge of lag buys clean outputs
      nxt_slope = slope_ns(b_loop_ff[dmr_pkg::SLOPE_LSB +: 2]);
      // [RQ15] phase align request
      nxt_align = b_loop_ff[dmr_pkg::ALIGN_BIT];
      // [RQ17] bandwidth from code
      nxt_bw = bw_hz(b_loop_ff[dmr_pkg::BW_LSB +: 3]);
   end

   // Settings reset to zero
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_fb_ff <= 1'b0;
         slope_ff <= 20'h00000;
         align_ff <= 1'b0;
         bw_ff <= 10'h000;
      end else begin
         ext_fb_ff <= nxt_ext_fb;
         slope_ff <= nxt_slope;
         align_ff <= nxt_align;
         bw_ff <= nxt_bw;
      end
   end

   // Outputs; state and selection come straight from selector flip-flops
   assign rd_data_o = rd_data_ff;
   assign rd_valid_o = rd_valid_ff;
   assign pll_a_state_o = sel_bus.state;
   assign pll_a_selected_ref_o = sel_bus.sel_ref;
   assign pll_a_external_feedback_enable_o = ext_fb_ff;
   assign pll_b_slope_limit_o = slope_ff;
   assign pll_b_phase_align_clear_o = align_ff;
   assign pll_b_bandwidth_hz_o = bw_ff;

   // ==========================================================================
   // Checks
   sequence loop_write_s;
      wr_en_i && addr_i == dmr_pkg::ADDR_B_LOOP_CTRL &&
      wr_data_i[dmr_pkg::BW_LSB +: 3] != dmr_pkg::BW_RESERVED;
   endsequence

   // Output two edges after the strobe
   bw_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ17]
      loop_write_s |=> ##1 bw_ff == bw_hz($past(wr_data_i[dmr_pkg::BW_LSB +: 3], 2)))
      else $error("bandwidth output wrong after write");

   // Code 7 never stored
   bw_reserved_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ17]
      b_loop_ff[dmr_pkg::BW_LSB +: 3] != dmr_pkg::BW_RESERVED)
      else $error("reserved bandwidth code stored");

   // Decode lags the code by one edge
   slope_map_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ14]
      $past(b_loop_ff[dmr_pkg::SLOPE_LSB +: 2]) == 2'h1 |-> slope_ff == dmr_pkg::SLOPE_7P5_US_NS)
      else $error("slope limit mismatch");

   // Reserved fields never move
   reserved_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ22]
      mode_refsel_ff[4:2] == 3'h3 && b_loop_ff[1:0] == 2'h0 && b_prio_ff[7] == 1'b0)
      else $error("reserved bits changed");

   // Auto mode reads back the live choice
   status_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ8]
      rd_en_i && addr_i == dmr_pkg::ADDR_A_MODE_REFSEL &&
      mode_refsel_ff[1:0] == dmr_pkg::MODE_AUTO
      |=> rd_valid_ff && rd_data_ff[7:6] == $past(sel_bus.sel_ref))
      else $error("automatic status not read back");

   // Enable is a one-edge copy
   fb_enable_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ6]
      ##1 ext_fb_ff == $past(mode_refsel_ff[dmr_pkg::EXT_FB_BIT]))
      else $error("feedback enable not followed");

   // Mode register write
   sequence mode_write_s;
      wr_en_i && addr_i == dmr_pkg::ADDR_A_MODE_REFSEL;
   endsequence

   refsel_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ8]
      mode_write_s ##0 wr_data_i[1:0] == dmr_pkg::MODE_AUTO
      |=> mode_refsel_ff[7:6] == $past(mode_refsel_ff[7:6]))
      else $error("status field overwritten");

   // Forcing write stores the reference
   refsel_force_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ9]
      mode_write_s ##0 wr_data_i[1:0] == dmr_pkg::MODE_FORCED_LOCK
      |=> mode_refsel_ff[7:6] == $past(wr_data_i[7:6]))
      else $error("forced reference not stored");

   // Selection frozen outside lock modes
   idle_sel_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ10]
      sel_bus.mode == dmr_pkg::MODE_FREERUN || sel_bus.mode == dmr_pkg::MODE_FORCED_HOLD
      |=> sel_bus.sel_ref == $past(sel_bus.sel_ref))
      else $error("selection moved");

   // All mask bits writable
   mask_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ13]
      wr_en_i && addr_i == dmr_pkg::ADDR_A_FAIL_MASKS |=> fail_masks_ff == $past(wr_data_i))
      else $error("failure masks not stored");

   // Align request is a one-edge copy
   align_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ15]
      ##1 align_ff == $past(b_loop_ff[dmr_pkg::ALIGN_BIT]))
      else $error("align clear not followed");
endmodule // dmr_control

//--- tb/dmr_control_tb.sv
// Self-checking testbench for the PLL mode and reference-select control block
`timescale 1ns/1ps
module dmr_control_tb;
   // ==========================================================================
   // Stimulus, observed outputs and bookkeeping
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic wr_en_i = 1'b0;
   logic [7:0] wr_data_i = 8'h00;
   logic rd_en_i = 1'b0;
   logic [15:0] ref_fail_i = 16'h0000;
   logic [11:0] pll_a_priority_i = 12'h010;
   logic [7:0] rd_data_o;
   logic rd_valid_o;
   logic [2:0] pll_a_state_o;
   logic [1:0] pll_a_selected_ref_o;
   logic pll_a_external_feedback_enable_o;
   logic [19:0] pll_b_slope_limit_o;
   logic pll_b_phase_align_clear_o;
   logic [9:0] pll_b_bandwidth_hz_o;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] exp_q[$];
   logic [7:0] exp_rd;
   logic [7:0] d;
   logic [2:0] bw_old;
   logic [19:0] slope_tab [4] = '{dmr_pkg::SLOPE_61_US_NS, dmr_pkg::SLOPE_7P5_US_NS,
      dmr_pkg::SLOPE_0P885_US_NS, dmr_pkg::SLOPE_UNLIMITED};

   dmr_control u_dut (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .addr_i(addr_i),
      .wr_en_i(wr_en_i),
      .wr_data_i(wr_data_i),
      .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o),
      .rd_valid_o(rd_valid_o),
      .ref_fail_i(ref_fail_i),
      .pll_a_priority_i(pll_a_priority_i),
      .pll_a_state_o(pll_a_state_o),
      .pll_a_selected_ref_o(pll_a_selected_ref_o),
      .pll_a_external_feedback_enable_o(pll_a_external_feedback_enable_o),
      .pll_b_slope_limit_o(pll_b_slope_limit_o),
      .pll_b_phase_align_clear_o(pll_b_phase_align_clear_o),
      .pll_b_bandwidth_hz_o(pll_b_bandwidth_hz_o)
   );

   // ==========================================================================
   // Clock and hang guard; the ceiling is far above the few hundred cycles used
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         stop_test();
      end
   end

   // ==========================================================================
   // Compare tasks and verdict
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: read got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: output got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk_a(input logic [2:0] st, input logic [1:0] r);
      cmp_val({17'h00000, pll_a_state_o}, {17'h00000, st});
      cmp_val({18'h00000, pll_a_selected_ref_o}, {18'h00000, r});
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================================
   // Register port drivers; strobes are held across exactly one taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      #1;
      addr_i = a;
      wr_data_i = v;
      wr_en_i = 1'b1;
      @(posedge clk_i);
      #1;
      wr_en_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      #1;
      addr_i = a;
      exp_q.push_back(e);
      rd_en_i = 1'b1;
      @(posedge clk_i);
      #1;
      rd_en_i = 1'b0;
   endtask
   // Gives the two-edge write path and the selector time to land
   task automatic settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   // Read results are matched to the oldest note, sampled mid-cycle when settled
   always @(negedge clk_i) begin
      if (rd_valid_o === 1'b1) begin
         exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         cmp_rd(rd_data_o, exp_rd);
      end
   end

   // ==========================================================================
   // Main sequence
   initial begin
      void'($urandom(32'h3D91));
      repeat (4) @(posedge clk_i);
      #1;
      rstn_i = 1'b1;
      settle();
      // Reset values, unmapped read and decoded defaults
      rd(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h0F);
      rd(dmr_pkg::ADDR_A_FAIL_MASKS, 8'h87);
      rd(dmr_pkg::ADDR_B_LOOP_CTRL, 8'h0C);
      rd(dmr_pkg::ADDR_B_PRIO_23, 8'h32);
      rd(8'h40, 8'h00);
      cmp_val(pll_b_slope_limit_o, dmr_pkg::SLOPE_UNLIMITED);
      cmp_val({10'h000, pll_b_bandwidth_hz_o}, 20'h0000E);
      // Every slope and bandwidth code; code 7 must keep the previous one
      bw_old = 3'h0;
      for (int i = 0; i < 8; i++) begin
         d = {i[2:0], i[0], i[1:0], 2'b11};
         if (i != 7) bw_old = i[2:0];
         wr(dmr_pkg::ADDR_B_LOOP_CTRL, d);
         settle();
         cmp_val(pll_b_slope_limit_o, slope_tab[i[1:0]]);
         cmp_val({10'h000, pll_b_bandwidth_hz_o}, {10'h000, 10'h00E << bw_old});
         cmp_val({19'h00000, pll_b_phase_align_clear_o}, {19'h00000, i[0]});
         rd(dmr_pkg::ADDR_B_LOOP_CTRL, {bw_old, i[0], i[1:0], 2'b00});
      end
      // Feedback enable and reserved bits of the mode register
      wr(dmr_pkg::ADDR_A_MODE_REFSEL, 8'hFF);
      settle();
      cmp_val({19'h00000, pll_a_external_feedback_enable_o}, 20'h00001);
      rd(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h2F);
      wr(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h03);
      settle();
      cmp_val({19'h00000, pll_a_external_feedback_enable_o}, 20'h00000);
      // Random mask and priority bytes; guard-only holdover mask is never written
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom());
         wr(dmr_pkg::ADDR_B_PRIO_23, d);
         rd(dmr_pkg::ADDR_B_PRIO_23, d & 8'h77);
         if (d[3:1] == 3'b100) d[1] = 1'b1;
         wr(dmr_pkg::ADDR_A_FAIL_MASKS, d);
         rd(dmr_pkg::ADDR_A_FAIL_MASKS, d);
      end
      wr(dmr_pkg::ADDR_A_FAIL_MASKS, 8'h87);
      // Forced lock on each reference, then holdover without switching
      for (int r = 0; r < 4; r++) begin
         wr(dmr_pkg::ADDR_A_MODE_REFSEL, {r[1:0], 6'h02});
         settle();
         chk_a(dmr_pkg::ST_LOCKED, r[1:0]);
         rd(dmr_pkg::ADDR_A_MODE_REFSEL, {r[1:0], 6'h0E});
         ref_fail_i = 16'h0001 << (4 * r);
         settle();
         chk_a(dmr_pkg::ST_HOLDOVER, r[1:0]);
         ref_fail_i = 16'h0000;
         settle();
      end
      // Cleared holdover mask keeps the loop locked through failures
      wr(dmr_pkg::ADDR_A_FAIL_MASKS, 8'h80);
      ref_fail_i = 16'hF000;
      settle();
      chk_a(dmr_pkg::ST_LOCKED, 2'h3);
      wr(dmr_pkg::ADDR_A_FAIL_MASKS, 8'h87);
      settle();
      chk_a(dmr_pkg::ST_HOLDOVER, 2'h3);
      ref_fail_i = 16'h0000;
      // Forced holdover and freerun ignore the reference field
      wr(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h01);
      settle();
      chk_a(dmr_pkg::ST_HOLDOVER, 2'h3);
      wr(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h40);
      settle();
      chk_a(dmr_pkg::ST_FREERUN, 2'h3);
      wr(dmr_pkg::ADDR_B_LOOP_CTRL, 8'h0C);
      // Automatic selection: ref3 excluded, ref1 and ref2 share a priority
      pll_a_priority_i = {3'h7, 3'h1, 3'h1, 3'h2};
      wr(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h03);
      settle();
      chk_a(dmr_pkg::ST_LOCKED, 2'h1);
      rd(dmr_pkg::ADDR_A_MODE_REFSEL, 8'h4F);
      ref_fail_i = 16'h0010;
      settle();
      chk_a(dmr_pkg::ST_LOCKED, 2'h1);
      ref_fail_i = 16'h0080;
      settle();
      chk_a(dmr_pkg::ST_LOCKED, 2'h2);
      ref_fail_i = 16'h0000;
      settle();
      chk_a(dmr_pkg::ST_LOCKED, 2'h2);
      pll_a_priority_i[2:0] = 3'h0;
      settle();
      chk_a(dmr_pkg::ST_LOCKED, 2'h0);
      ref_fail_i = 16'h0999;
      settle();
      cmp_val({17'h00000, pll_a_state_o}, {17'h00000, dmr_pkg::ST_HOLDOVER});
      settle();
      stop_test();
   end
endmodule // dmr_control_tb
